//--- common/gpio_pkg.sv
// Shared constants and types for the general-purpose pin port.
package gpio_pkg;

  // Port geometry: two banks of sixteen pins each.
  localparam int PIN_COUNT    = 32;
  localparam int BANK_PINS    = 16;
  localparam int BANK1_LSB    = 16;
  localparam int DATA_W       = 32;
  localparam int STRB_W       = DATA_W / 8;
  localparam int BYTE_W       = 8;
  localparam int ADDR_W       = 4;
  localparam int WORD_LSB     = 2;

  // Byte addresses of the registers on the bus.
  localparam logic [ADDR_W-1:0] OFFSET_DIRECTION    = 4'h0;
  localparam logic [ADDR_W-1:0] OFFSET_OUTPUT_RAISE = 4'h4;
  localparam logic [ADDR_W-1:0] OFFSET_OUTPUT_CLEAR = 4'h8;
  localparam logic [ADDR_W-1:0] OFFSET_PIN_LEVEL    = 4'hC;

  // Reset values: every pin starts as an input and drives low.
  localparam logic [PIN_COUNT-1:0] RESET_DIRECTION   = 32'hFFFFFFFF;
  localparam logic [PIN_COUNT-1:0] RESET_DRIVE_STATE = 32'h00000000;
  localparam logic [PIN_COUNT-1:0] RESET_PIN_LEVEL   = 32'h00000000;
  localparam logic [DATA_W-1:0]    READ_ZERO         = 32'h00000000;

  // A direction bit of this value makes the pin an output.
  localparam logic DIR_OUTPUT = 1'b0;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register selected by an address.
  typedef enum logic [2:0] {
    SEL_DIRECTION,
    SEL_OUTPUT_RAISE,
    SEL_OUTPUT_CLEAR,
    SEL_PIN_LEVEL,
    SEL_NONE
  } reg_sel_t;

endpackage

//--- hw/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

// Three-stage synchroniser for the pin inputs; a level change is accepted
// once the second and third stages agree on it.
module pin_sync #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk,     // Peripheral clock.
  input  wire logic             reset_n, // Synchronous reset, active low.
  input  wire logic [WIDTH-1:0] raw,     // Asynchronous pin levels.
  output logic      [WIDTH-1:0] level    // Filtered, synchronised levels.
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] level;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  // Shift the stages and accept bits on which stages two and three agree.
  always_comb begin
    next_state        = state;
    next_state.stage1 = raw;
    next_state.stage2 = state.stage1;
    next_state.stage3 = state.stage2;
    for (int i = 0; i < WIDTH; i++) begin
      if (state.stage2[i] == state.stage3[i]) begin
        next_state.level[i] = state.stage3[i];
      end
    end
  end

  // Register the synchroniser state; everything clears to low at reset.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign level = state.level;

endmodule

`default_nettype wire

//--- hw/gpio_clear_input.sv
`timescale 1ns/100ps
`default_nettype none

module gpio_clear_input
  import gpio_pkg::*;
(
  input  wire logic                 clk,           // Peripheral clock, 10 MHz.
  input  wire logic                 reset_n,       // Synchronous reset, active low.
  // AXI4-Lite write address channel.
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,  // Write byte address.
  input  wire logic [2:0]           s_axi_awprot,  // Protection, unused.
  input  wire logic                 s_axi_awvalid, // Write address valid.
  output logic                      s_axi_awready, // Write address ready.
  // AXI4-Lite write data channel.
  input  wire logic [DATA_W-1:0]    s_axi_wdata,   // Write data.
  input  wire logic [STRB_W-1:0]    s_axi_wstrb,   // Byte lane strobes.
  input  wire logic                 s_axi_wvalid,  // Write data valid.
  output logic                      s_axi_wready,  // Write data ready.
  // AXI4-Lite write response channel.
  output logic [1:0]                s_axi_bresp,   // Write response.
  output logic                      s_axi_bvalid,  // Write response valid.
  input  wire logic                 s_axi_bready,  // Write response ready.
  // AXI4-Lite read address channel.
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,  // Read byte address.
  input  wire logic [2:0]           s_axi_arprot,  // Protection, unused.
  input  wire logic                 s_axi_arvalid, // Read address valid.
  output logic                      s_axi_arready, // Read address ready.
  // AXI4-Lite read data channel.
  output logic [DATA_W-1:0]         s_axi_rdata,   // Read data.
  output logic [1:0]                s_axi_rresp,   // Read response.
  output logic                      s_axi_rvalid,  // Read data valid.
  input  wire logic                 s_axi_rready,  // Read data ready.
  // General-purpose pins.
  input  wire logic [PIN_COUNT-1:0] pin_in,        // Level seen on each pin.
  output logic      [PIN_COUNT-1:0] pin_out,       // Level driven on each pin.
  output logic      [PIN_COUNT-1:0] pin_oe         // High while the pin is driven.
);

  // Register map, one aligned 32-bit word each: direction at byte 0x0, raise at
  // 0x4, clear at 0x8 and pin level at 0xC. Any other address is answered with
  // a slave error and changes nothing, so a stray access shows up in software.
  //
  // Timing: a write takes effect at the edge at which the later of its address
  // and data is taken, and its response rises at that same edge. A read samples
  // its source at the edge at which the address is taken, so read data always
  // show the state from before any write completing at that edge.
  //
  // Raise and clear share one drive state, so software never needs a
  // read-modify-write to move one pin; that is why both words read it back.

  // All state of the block in one record. The bus slave keeps a parked write
  // address and data item, the two response registers and the read word; the
  // pin side keeps the direction word and the shared drive state.
  typedef struct packed {
    logic                  aw_held;
    logic [ADDR_W-1:0]     aw_addr;
    logic                  w_held;
    logic [DATA_W-1:0]     w_data;
    logic [STRB_W-1:0]     w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [DATA_W-1:0]     rdata;
    logic [1:0]            rresp;
    logic [PIN_COUNT-1:0]  direction_bit;
    logic [PIN_COUNT-1:0]  drive_state;
  } port_state_t;

  port_state_t state;
  port_state_t next_state;

  // Per-pin views of the state.
  logic [PIN_COUNT-1:0] synced_level;
  logic [PIN_COUNT-1:0] pin_level_word;
  logic [PIN_COUNT-1:0] output_clear_word;
  logic [PIN_COUNT-1:0] output_mask;

  // Bus decode and handshake terms.
  logic                 aw_fire;
  logic                 w_fire;
  logic                 ar_fire;
  logic                 write_go;
  logic [ADDR_W-1:0]    write_addr;
  logic [DATA_W-1:0]    write_data;
  logic [STRB_W-1:0]    write_strb;
  logic [DATA_W-1:0]    write_bits;
  reg_sel_t             write_sel;
  reg_sel_t             read_sel;

  // Decodes a byte address to the register it selects. The low two bits must
  // be zero: an unaligned address falls to the default and is refused, rather
  // than aliasing onto the word that contains it.
  function automatic reg_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    unique case (addr)
      OFFSET_DIRECTION:    sel = SEL_DIRECTION;
      OFFSET_OUTPUT_RAISE: sel = SEL_OUTPUT_RAISE;
      OFFSET_OUTPUT_CLEAR: sel = SEL_OUTPUT_CLEAR;
      OFFSET_PIN_LEVEL:    sel = SEL_PIN_LEVEL;
      default:             sel = SEL_NONE;
    endcase
    return sel;
  endfunction

  // Expands byte strobes into a per-bit mask. Byte lanes left off by the master
  // keep their old contents in the direction word and have no effect on the
  // raise and clear words, so a narrow write touches only its own pins.
  function automatic logic [DATA_W-1:0] strobe_mask(input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] mask;
    mask = '0;
    for (int b = 0; b < STRB_W; b++) begin
      mask[b*BYTE_W +: BYTE_W] = {BYTE_W{strb[b]}};
    end
    return mask;
  endfunction

  // Pin inputs cross into the clock domain through three stages. Only input
  // pins use this path; the extra latency of a few cycles is the price of never
  // letting a metastable level reach the read data.
  pin_sync #(
    .WIDTH (PIN_COUNT)
  ) u_pin_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .raw     (pin_in),
    .level   (synced_level)
  );

  // Output pins are those whose direction bit selects output. The enable is a
  // plain inversion of a register, so it changes only at a clock edge.
  assign output_mask = ~state.direction_bit;

  // Bit n of both words serves pin n, so bank 1 sits above bank 0.
  // Bank 0 holds pins 0 to 15 and bank 1 pins 16 to 31; there is no gap or
  // reordering between them, so one 32-bit word covers both banks.
  // bank bit mapping
  assign output_clear_word = state.drive_state;

  // An output pin reads back its own drive state without the synchroniser
  // delay, so software sees a value it has just written at once. An input pin
  // reads the filtered level, which lags the pin by four edges.
  // per-pin level source
  generate
    for (genvar n = 0; n < PIN_COUNT; n++) begin : g_level
      assign pin_level_word[n] = (state.direction_bit[n] == DIR_OUTPUT) ?
                                 state.drive_state[n] : synced_level[n];
    end
  endgenerate

  // Bus handshakes; a new request waits until the previous answer is taken.
  // Closing the write channels while a response is pending keeps at most one
  // write in flight, so the response registers never need a queue. The read
  // channel is independent and may overlap a write.
  assign s_axi_awready = !state.aw_held && !state.bvalid;
  assign s_axi_wready  = !state.w_held && !state.bvalid;
  assign s_axi_arready = !state.rvalid;
  assign aw_fire       = s_axi_awvalid && s_axi_awready;
  assign w_fire        = s_axi_wvalid && s_axi_wready;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;

  // A write runs in the cycle in which both address and data are present.
  // Either half may arrive first; the early one is parked in the state record
  // and its ready drops until the partner arrives, which keeps it from being
  // overwritten by a second item on the same channel.
  assign write_go   = (state.aw_held || aw_fire) && (state.w_held || w_fire);
  assign write_addr = state.aw_held ? state.aw_addr : s_axi_awaddr;
  assign write_data = state.w_held ? state.w_data : s_axi_wdata;
  assign write_strb = state.w_held ? state.w_strb : s_axi_wstrb;
  assign write_bits = write_data & strobe_mask(write_strb);
  assign write_sel  = decode_addr(write_addr);
  assign read_sel   = decode_addr(s_axi_araddr);

  // Next-state logic for the bus slave and the pin registers. Every field
  // starts from its present value, so anything not named below holds.
  always_comb begin
    next_state = state;

    // Hold an address or data item that arrives before its partner. An item
    // that arrives together with its partner is used directly and not parked.
    if (aw_fire && !write_go) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (w_fire && !write_go) begin
      next_state.w_held = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
    end

    // Retire the write response once the master accepts it. No new write can
    // complete in the same cycle, since both write readies are low meanwhile.
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end

    // Carry out a complete write and raise its response. Raise and clear both
    // mask their bits with the output pins, so an input pin keeps its stored
    // drive state and picks it up again once it is turned into an output.
    if (write_go) begin
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = RESP_OKAY;
      unique case (write_sel)
        SEL_DIRECTION: begin
          next_state.direction_bit = (state.direction_bit & ~strobe_mask(write_strb)) | write_bits;
        end
        SEL_OUTPUT_RAISE: begin
          next_state.drive_state = state.drive_state | (write_bits & output_mask);
        end
        SEL_OUTPUT_CLEAR: begin
          next_state.drive_state = state.drive_state & ~(write_bits & output_mask);
        end
        SEL_PIN_LEVEL: begin
          next_state.bresp = RESP_OKAY;
        end
        SEL_NONE: begin
          // Unmapped address: refuse without effect.
          next_state.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Retire the read data once the master accepts it. The address ready is
    // low while data are pending, so a retire and a capture never collide.
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end

    // Capture the read data at the cycle the address is taken. The data are
    // registered and held with the valid flag, so a slow master sees a stable
    // word however long it keeps ready low.
    if (ar_fire) begin
      next_state.rvalid = 1'b1;
      next_state.rresp  = RESP_OKAY;
      unique case (read_sel)
        SEL_DIRECTION: begin
          next_state.rdata = state.direction_bit;
        end
        SEL_OUTPUT_RAISE: begin
          // The raise word reads back the same drive state.
          next_state.rdata = state.drive_state;
        end
        SEL_OUTPUT_CLEAR: begin
          next_state.rdata = output_clear_word;
        end
        SEL_PIN_LEVEL: begin
          next_state.rdata = pin_level_word;
        end
        SEL_NONE: begin
          // Unmapped address: refuse and return zero.
          next_state.rdata = READ_ZERO;
          next_state.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // Register the whole state; reset makes every pin an input driving low.
  // The reset is synchronous, so the clock must run while it is held; the
  // bus readies are combinational and already high during reset.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state               <= '0;
      state.direction_bit <= RESET_DIRECTION;
      state.drive_state   <= RESET_DRIVE_STATE;
    end else begin
      state <= next_state;
    end
  end

  // Pins are driven from the stored drive state while they are outputs.
  // The pin value is presented even while the enable is low; the pad passes
  // it on only when the enable is high, so the value is harmless there.
  assign pin_out      = state.drive_state;
  assign pin_oe       = output_mask;
  assign s_axi_bvalid = state.bvalid;
  assign s_axi_bresp  = state.bresp;
  assign s_axi_rvalid = state.rvalid;
  assign s_axi_rdata  = state.rdata;
  assign s_axi_rresp  = state.rresp;

endmodule

`default_nettype wire

//--- tb/pin_partner.sv
`timescale 1ns/100ps
`default_nettype none

// Outside circuitry: a pin reads its own drive while driven, else the level set by the bench.
module pin_partner
  import gpio_pkg::*;
(
  input  wire logic [PIN_COUNT-1:0] pin_out,   // Device drive.
  input  wire logic [PIN_COUNT-1:0] pin_oe,    // Device enable.
  input  wire logic [PIN_COUNT-1:0] ext_level, // Outside level.
  output logic      [PIN_COUNT-1:0] pin_in     // Wire level.
);
  // Resolve each wire from both parties.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

`default_nettype wire

//--- tb/gpio_clear_input_checker.sv
`timescale 1ns/100ps
`default_nettype none

// Ties the drive state and readback to the bus requests that cause them.
module gpio_clear_input_checker
  import gpio_pkg::*;
(
  input wire logic                 clk,           // Clock.
  input wire logic                 reset_n,       // Reset.
  input wire logic [ADDR_W-1:0]    s_axi_awaddr,  // Write address.
  input wire logic                 s_axi_awvalid, // Address valid.
  input wire logic                 s_axi_awready, // Address ready.
  input wire logic [DATA_W-1:0]    s_axi_wdata,   // Write data.
  input wire logic [STRB_W-1:0]    s_axi_wstrb,   // Byte strobes.
  input wire logic                 s_axi_wvalid,  // Data valid.
  input wire logic                 s_axi_wready,  // Data ready.
  input wire logic                 s_axi_bvalid,  // Response valid.
  input wire logic [ADDR_W-1:0]    s_axi_araddr,  // Read address.
  input wire logic                 s_axi_arvalid, // Read valid.
  input wire logic                 s_axi_arready, // Read ready.
  input wire logic [DATA_W-1:0]    s_axi_rdata,   // Read data.
  input wire logic [PIN_COUNT-1:0] pin_out,       // Drive state.
  input wire logic [PIN_COUNT-1:0] pin_oe         // Drive enable.
);
  logic              wt;
  logic              rt;
  logic [DATA_W-1:0] wbits;

  // Write data with the byte lanes that are switched off zeroed.
  always_comb begin
    wbits = s_axi_wdata;
    for (int b = 0; b < STRB_W; b++) begin
      if (!s_axi_wstrb[b]) begin
        wbits[b*BYTE_W +: BYTE_W] = '0;
      end
    end
  end

  // Both write halves or a read taken at this edge.
  assign wt = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rt = s_axi_arvalid && s_axi_arready;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  write_answer_a: assert property (wt |=> s_axi_bvalid)
    else $error("write not answered");
  clear_low_a: assert property (wt && s_axi_awaddr == OFFSET_OUTPUT_CLEAR |=>
    (pin_out & $past(wbits) & $past(pin_oe)) == '0) else $error("clear missed");
  clear_input_a: assert property (wt && s_axi_awaddr == OFFSET_OUTPUT_CLEAR |=>
    ((pin_out ^ $past(pin_out)) & ~$past(pin_oe)) == '0) else $error("input pin changed");
  clear_zero_a: assert property (wt && s_axi_awaddr == OFFSET_OUTPUT_CLEAR |=>
    ((pin_out ^ $past(pin_out)) & ~$past(wbits)) == '0) else $error("zero bit acted");
  raise_high_a: assert property (wt && s_axi_awaddr == OFFSET_OUTPUT_RAISE |=>
    (~pin_out & $past(wbits) & $past(pin_oe)) == '0) else $error("raise missed");
  clear_read_a: assert property (rt && s_axi_araddr == OFFSET_OUTPUT_CLEAR |=>
    s_axi_rdata == $past(pin_out)) else $error("clear readback wrong");
  level_output_a: assert property (rt && s_axi_araddr == OFFSET_PIN_LEVEL |=>
    ((s_axi_rdata ^ $past(pin_out)) & $past(pin_oe)) == '0) else $error("output level wrong");
  level_write_a: assert property (wt && s_axi_awaddr == OFFSET_PIN_LEVEL |=>
    $stable(pin_out) && $stable(pin_oe)) else $error("level write acted");

  // Main scenarios.
  cover property (wt && s_axi_awaddr == OFFSET_OUTPUT_CLEAR);
  cover property (wt && s_axi_awaddr == OFFSET_OUTPUT_RAISE);
  cover property (rt && s_axi_araddr == OFFSET_PIN_LEVEL);
endmodule

`default_nettype wire

//--- tb/tb_gpio_clear_input.sv
`timescale 1ns/100ps
`default_nettype none

// Drives register traffic and outside pin levels, and compares readback.
module tb_gpio_clear_input
  import gpio_pkg::*;
;
  logic                 clk = 1'b0;
  logic                 reset_n;
  logic [ADDR_W-1:0]    s_axi_awaddr, s_axi_araddr;
  logic [2:0]           s_axi_awprot, s_axi_arprot;
  logic [DATA_W-1:0]    s_axi_wdata, s_axi_rdata;
  logic [STRB_W-1:0]    s_axi_wstrb;
  logic [1:0]           s_axi_bresp, s_axi_rresp;
  logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                 s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                 s_axi_rvalid, s_axi_rready;
  logic [PIN_COUNT-1:0] pin_in, pin_out, pin_oe, ext_level;
  int                   n_mismatch, checks;

  gpio_clear_input u_gpio_clear_input (
    .clk           (clk),
    .reset_n       (reset_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awprot  (s_axi_awprot),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arprot  (s_axi_arprot),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .pin_in        (pin_in),
    .pin_out       (pin_out),
    .pin_oe        (pin_oe)
  );
  pin_partner u_pin_partner (
    .pin_out   (pin_out),
    .pin_oe    (pin_oe),
    .ext_level (ext_level),
    .pin_in    (pin_in)
  );

  // Clock of 100 ns period.
  always #50 clk = ~clk;

  task automatic tally_and_finish;
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Write both halves at once, release each when taken, end at the response edge.
  task automatic wchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] er = RESP_OKAY);
    bit da, dw, db;
    da = 0;
    dw = 0;
    db = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 50 && !db; n++) begin
      @(negedge clk);
      da |= s_axi_awready;
      dw |= s_axi_wready;
      db = s_axi_bvalid;
      if (db) chk({30'h0, s_axi_bresp}, {30'h0, er});
      @(posedge clk);
      if (da && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (dw && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end
    if (!db) begin
      n_mismatch++;
      tally_and_finish;
    end
  endtask

  // Read one word and compare it and its response.
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic [1:0] er = RESP_OKAY);
    bit ta, dr;
    dr = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 50 && !dr; n++) begin
      @(negedge clk);
      ta = s_axi_arready;
      dr = s_axi_rvalid;
      if (dr) chk(s_axi_rdata, e);
      if (dr) chk({30'h0, s_axi_rresp}, {30'h0, er});
      @(posedge clk);
      if (ta && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end
    if (!dr) begin
      n_mismatch++;
      tally_and_finish;
    end
  endtask

  // Main sequence.
  initial begin
    {reset_n, s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, ext_level} = '0;
    {n_mismatch, checks} = '0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rchk(OFFSET_PIN_LEVEL, 32'h00000000);
    rchk(OFFSET_OUTPUT_CLEAR, 32'h00000000);
    wchk(OFFSET_DIRECTION, 32'hFF00FF00);
    wchk(OFFSET_OUTPUT_RAISE, 32'hFFFFFFFF);
    rchk(OFFSET_OUTPUT_CLEAR, 32'h00FF00FF);
    chk(pin_oe, 32'h00FF00FF);
    wchk(OFFSET_OUTPUT_CLEAR, 32'hF0F0F0F0);
    rchk(OFFSET_OUTPUT_CLEAR, 32'h000F000F);
    chk(pin_out, 32'h000F000F);
    ext_level <= 32'hA5A5A5A5;
    repeat (6) @(posedge clk);
    rchk(OFFSET_PIN_LEVEL, 32'hA50FA50F);
    wchk(OFFSET_PIN_LEVEL, 32'hFFFFFFFF);
    rchk(OFFSET_PIN_LEVEL, 32'hA50FA50F);
    wchk(OFFSET_DIRECTION, 32'hFFFFFFFF);
    repeat (6) @(posedge clk);
    rchk(OFFSET_PIN_LEVEL, 32'hA5A5A5A5);
    wchk(OFFSET_OUTPUT_CLEAR, 32'hFFFFFFFF);
    wchk(OFFSET_DIRECTION, 32'hFF00FF00);
    rchk(OFFSET_OUTPUT_CLEAR, 32'h000F000F);
    s_axi_wstrb <= 4'h1;
    wchk(OFFSET_OUTPUT_RAISE, 32'hFFFFFFFF);
    s_axi_wstrb <= 4'hF;
    rchk(OFFSET_OUTPUT_CLEAR, 32'h000F00FF);
    wchk(4'h2, 32'hFFFFFFFF, RESP_SLVERR);
    rchk(4'h2, READ_ZERO, RESP_SLVERR);
    rchk(OFFSET_OUTPUT_CLEAR, 32'h000F00FF);
    ext_level <= 32'h5A5A5A5A;
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rchk(OFFSET_PIN_LEVEL, READ_ZERO);
    chk(pin_oe, READ_ZERO);
    rchk(OFFSET_OUTPUT_CLEAR, READ_ZERO);
    tally_and_finish;
  end
endmodule

bind gpio_clear_input gpio_clear_input_checker u_gpio_clear_input_checker (
  .clk           (clk),
  .reset_n       (reset_n),
  .s_axi_awaddr  (s_axi_awaddr),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_wdata   (s_axi_wdata),
  .s_axi_wstrb   (s_axi_wstrb),
  .s_axi_wvalid  (s_axi_wvalid),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_araddr  (s_axi_araddr),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rdata   (s_axi_rdata),
  .pin_out       (pin_out),
  .pin_oe        (pin_oe)
);

`default_nettype wire
